// File: logic/lcd_cmd_defines.vh
// Command codes, field positions, reset values and timing for the LCD command decoder.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef LCD_CMD_DEFINES_VH
`define LCD_CMD_DEFINES_VH

// Full-byte command codes
`define CMD_DISP_OFF      8'hae
`define CMD_DISP_ON       8'haf
`define CMD_ADC_NORM      8'ha0
`define CMD_ADC_REV       8'ha1
`define CMD_INV_OFF       8'ha6
`define CMD_INV_ON        8'ha7
`define CMD_ALLON_OFF     8'ha4
`define CMD_ALLON_ON      8'ha5
`define CMD_BIAS_LO       8'ha2
`define CMD_BIAS_HI       8'ha3
`define CMD_IND_OFF       8'hac
`define CMD_IND_ON        8'had
`define CMD_RMW           8'he0
`define CMD_RMW_END       8'hee
`define CMD_SOFT_RESET    8'he2
`define CMD_TEST_EXIT     8'hf0

// Prefix matches: mask and value
`define PFX_START_MASK    8'hc0
`define PFX_START_VAL     8'h40
`define PFX_PAGE_MASK     8'hf0
`define PFX_PAGE_VAL      8'hb0
`define PFX_COLHI_MASK    8'hf0
`define PFX_COLHI_VAL     8'h10
`define PFX_COLLO_MASK    8'hf0
`define PFX_COLLO_VAL     8'h00
`define PFX_SCAN_MASK     8'hf0
`define PFX_SCAN_VAL      8'hc0
`define PFX_PWR_MASK      8'hf8
`define PFX_PWR_VAL       8'h28
`define PFX_CONTR_MASK    8'he0
`define PFX_CONTR_VAL     8'h80
`define PFX_TEST_MASK     8'hf0
`define PFX_TEST_VAL      8'hf0

// Field positions
`define SCAN_DIR_BIT      3
`define PWR_FOLLOWER_BIT  0
`define PWR_REGULATOR_BIT 1
`define PWR_BOOSTER_BIT   2

// Reset values and last column address
`define START_LINE_RST    6'h00
`define COLUMN_RST        8'h00
`define PAGE_RST          4'h0
`define SCAN_DIR_RST      1'b0
`define PWR_RST           3'h0
`define CONTRAST_RST      5'h00
`define COLUMN_LAST       8'h83

// Timing
`define CLK_FREQ_HZ       50000000
`define BLINK_PERIOD_MS   1000
`define BLINK_HALF_CYCLES ((`CLK_FREQ_HZ / 1000) * `BLINK_PERIOD_MS / 2)
`define BUSY_CYCLES       4'h2

`endif

// File: logic/serial_byte_shifter.v
// Serial command port: assembles bytes from a bit stream, first bit most significant.
// Assumes sclk_rise and bit_in are synchronous single-cycle qualified samples.
`timescale 1ns/100ps
module serial_byte_shifter (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Bit stream
  input  wire       chip_sel,
  input  wire       sclk_rise,
  input  wire       bit_in,
  // Byte out
  output reg  [7:0] byte_out,
  output reg        byte_valid
);

  reg [6:0] shift_r;
  reg [2:0] count_r;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_r    <= 7'h00;
      count_r    <= 3'h0;
      byte_out   <= 8'h00;
      byte_valid <= 1'b0;
    end else begin
      byte_valid <= 1'b0;
      if (!chip_sel) begin
        // Deselect realigns to a byte boundary
        count_r <= 3'h0;
      end else if (sclk_rise) begin
        shift_r <= {shift_r[5:0], bit_in};
        count_r <= count_r + 3'h1;
        if (count_r == 3'h7) begin
          byte_out   <= {shift_r, bit_in};
          byte_valid <= 1'b1;
        end
      end
    end
  end

endmodule

// File: logic/indicator_blinker.v
// Static indicator drive: toggles the indicator phase every half second.
// Assumes the run input is low whenever the indicator must rest.
`timescale 1ns/100ps
`include "lcd_cmd_defines.vh"
module indicator_blinker #(
  parameter HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire rst,
  // Control
  input  wire run,
  // Phase
  output reg  phase
);

  reg [31:0] count_r;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_r <= 32'h0000_0000;
      phase   <= 1'b0;
    end else if (!run) begin
      count_r <= 32'h0000_0000;
      phase   <= 1'b0;
    end else if (count_r >= HALF_CYCLES - 1) begin
      count_r <= 32'h0000_0000;
      phase   <= ~phase;
    end else begin
      count_r <= count_r + 32'h0000_0001;
    end
  end

endmodule

// File: logic/lcd_driver_command_decoder.v
// Command decoder of an LCD segment driver with on-chip display RAM.
// Assumes host strobes are synchronous to sys_clk; one strobe is one byte.
`timescale 1ns/100ps
`include "lcd_cmd_defines.vh"
module lcd_driver_command_decoder (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Parallel host port
  input  wire       command_data_select,
  input  wire       host_write,
  input  wire       host_read,
  input  wire [7:0] host_data,
  // Serial host port
  input  wire       serial_select,
  input  wire       serial_cs,
  input  wire       serial_clk_rise,
  input  wire       serial_bit,
  // Status and RAM addressing
  output reg  [7:0] status_byte,
  output reg  [7:0] column_address,
  output reg  [3:0] page_address,
  output reg  [5:0] start_line,
  output reg        ram_write_strobe,
  output reg        ram_read_strobe,
  output reg  [7:0] ram_write_data,
  // Display control
  output reg        display_on,
  output reg        adc_reverse,
  output reg        reverse_display,
  output reg        entire_on,
  output reg        bias_select,
  output reg        common_scan_direction,
  output reg  [2:0] power_circuit_select,
  output reg  [4:0] contrast_level,
  output reg        contrast_enable,
  // Power save and drive
  output reg        sleep_mode,
  output reg        standby_mode,
  output reg        oscillator_enable,
  output reg        supply_enable,
  output reg        outputs_to_vdd,
  output reg        display_off_link,
  output reg        static_indicator_output,
  output reg        frame_polarity_output,
  output reg        test_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Byte source

  localparam PS_RUN     = 2'd0;
  localparam PS_SLEEP   = 2'd1;
  localparam PS_STANDBY = 2'd2;

  wire [7:0] ser_byte;
  wire       ser_valid;
  wire       blink_phase;

  reg        ind_on_r;
  reg        rmw_r;
  reg  [7:0] rmw_save_r;
  reg  [1:0] ps_r;
  reg  [3:0] busy_r;
  reg        sleep_ind_r;

  serial_byte_shifter u_shift (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .chip_sel   (serial_select & serial_cs),
    .sclk_rise  (serial_clk_rise),
    .bit_in     (serial_bit),
    .byte_out   (ser_byte),
    .byte_valid (ser_valid)
  );

  // Indicator drive survives standby but not sleep
  indicator_blinker u_blink (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (ind_on_r & (ps_r != PS_SLEEP)),
    .phase   (blink_phase)
  );

  function match;
    input [7:0] b;
    input [7:0] m;
    input [7:0] v;
    begin
      match = ((b & m) == v);
    end
  endfunction

  wire       busy     = (busy_r != 4'h0);
  // Serial port carries commands only, never data writes or reads
  wire       wr_any   = serial_select ? ser_valid : host_write;
  wire [7:0] byte_in  = serial_select ? ser_byte : host_data;
  wire       is_data  = serial_select ? 1'b0 : command_data_select;
  // Read-modify-write mode gates nothing here: commands run as usual
  wire       cmd_take = wr_any & ~is_data & ~busy;
  wire       dat_wr   = wr_any & is_data;
  wire       dat_rd   = host_read & command_data_select & ~serial_select;

  function [7:0] col_inc;
    input [7:0] c;
    begin
      col_inc = (c == `COLUMN_LAST) ? c : c + 8'h01;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Command execution

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      column_address        <= `COLUMN_RST;
      page_address          <= `PAGE_RST;
      start_line            <= `START_LINE_RST;
      common_scan_direction <= `SCAN_DIR_RST;
      power_circuit_select  <= `PWR_RST;
      contrast_level        <= `CONTRAST_RST;
      display_on            <= 1'b0;
      adc_reverse           <= 1'b0;
      reverse_display       <= 1'b0;
      entire_on             <= 1'b0;
      bias_select           <= 1'b0;
      ind_on_r              <= 1'b0;
      rmw_r                 <= 1'b0;
      rmw_save_r            <= `COLUMN_RST;
      ps_r                  <= PS_RUN;
      sleep_ind_r           <= 1'b0;
      test_mode             <= 1'b0;
      busy_r                <= 4'h0;
      ram_write_strobe      <= 1'b0;
      ram_read_strobe       <= 1'b0;
      ram_write_data        <= 8'h00;
    end else begin
      ram_write_strobe <= dat_wr;
      ram_read_strobe  <= dat_rd;
      if (dat_wr) begin
        ram_write_data <= byte_in;
        column_address <= col_inc(column_address);
      end else if (dat_rd && !rmw_r) begin
        column_address <= col_inc(column_address);
      end
      if (busy)
        busy_r <= busy_r - 4'h1;
      if (cmd_take) begin
        if (match(byte_in, `PFX_START_MASK, `PFX_START_VAL)) begin
          start_line <= byte_in[5:0];
        end else if (match(byte_in, `PFX_PAGE_MASK, `PFX_PAGE_VAL)) begin
          page_address <= byte_in[3:0];
        end else if (match(byte_in, `PFX_COLHI_MASK, `PFX_COLHI_VAL)) begin
          column_address <= {byte_in[3:0], column_address[3:0]};
        end else if (match(byte_in, `PFX_COLLO_MASK, `PFX_COLLO_VAL)) begin
          column_address <= {column_address[7:4], byte_in[3:0]};
        end else if (match(byte_in, `PFX_SCAN_MASK, `PFX_SCAN_VAL)) begin
          common_scan_direction <= byte_in[`SCAN_DIR_BIT];
        end else if (match(byte_in, `PFX_PWR_MASK, `PFX_PWR_VAL)) begin
          power_circuit_select <= byte_in[2:0];
        end else if (match(byte_in, `PFX_CONTR_MASK, `PFX_CONTR_VAL)) begin
          contrast_level <= byte_in[4:0];
        end else if (byte_in == `CMD_TEST_EXIT) begin
          test_mode <= 1'b0;
        end else if (match(byte_in, `PFX_TEST_MASK, `PFX_TEST_VAL)) begin
          test_mode <= 1'b1;
        end else if (byte_in == `CMD_RMW) begin
          rmw_r      <= 1'b1;
          rmw_save_r <= column_address;
        end else if (byte_in == `CMD_RMW_END) begin
          rmw_r          <= 1'b0;
          column_address <= rmw_save_r;
        end else if (byte_in == `CMD_SOFT_RESET) begin
          // RAM and power supply state deliberately untouched
          start_line            <= `START_LINE_RST;
          column_address        <= `COLUMN_RST;
          page_address          <= `PAGE_RST;
          common_scan_direction <= `SCAN_DIR_RST;
          test_mode             <= 1'b0;
          busy_r                <= `BUSY_CYCLES;
          if (ps_r == PS_STANDBY)
            ps_r <= PS_SLEEP;
        end else if (byte_in == `CMD_IND_OFF || byte_in == `CMD_IND_ON) begin
          ind_on_r <= byte_in[0];
          if (byte_in[0])
            sleep_ind_r <= 1'b1;
        end else if (byte_in == `CMD_DISP_OFF || byte_in == `CMD_DISP_ON) begin
          display_on <= byte_in[0];
        end else if (byte_in == `CMD_ADC_NORM || byte_in == `CMD_ADC_REV) begin
          adc_reverse <= byte_in[0];
        end else if (byte_in == `CMD_INV_OFF || byte_in == `CMD_INV_ON) begin
          reverse_display <= byte_in[0];
        end else if (byte_in == `CMD_BIAS_LO || byte_in == `CMD_BIAS_HI) begin
          bias_select <= byte_in[0];
        end else if (byte_in == `CMD_ALLON_OFF || byte_in == `CMD_ALLON_ON) begin
          entire_on <= byte_in[0];
          if (byte_in[0] && !display_on && ps_r == PS_RUN) begin
            ps_r        <= ind_on_r ? PS_STANDBY : PS_SLEEP;
            sleep_ind_r <= 1'b0;
          end else if (!byte_in[0] && ps_r == PS_STANDBY) begin
            ps_r <= PS_RUN;
          end
        end
        // Sleep exit needs power save off and indicator on, in either order
        if (ps_r == PS_SLEEP && byte_in == `CMD_ALLON_OFF && (ind_on_r || sleep_ind_r))
          ps_r <= PS_RUN;
        if (ps_r == PS_SLEEP && byte_in == `CMD_IND_ON && !entire_on)
          ps_r <= PS_RUN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered drive and status outputs

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_byte             <= 8'h00;
      contrast_enable         <= 1'b0;
      sleep_mode              <= 1'b0;
      standby_mode            <= 1'b0;
      oscillator_enable       <= 1'b1;
      supply_enable           <= 1'b0;
      outputs_to_vdd          <= 1'b0;
      display_off_link        <= 1'b1;
      static_indicator_output <= 1'b0;
      frame_polarity_output   <= 1'b0;
    end else begin
      status_byte       <= {busy, adc_reverse, ~display_on, busy, 4'h0};
      contrast_enable   <= (contrast_level != 5'h00);
      sleep_mode        <= (ps_r == PS_SLEEP);
      standby_mode      <= (ps_r == PS_STANDBY);
      oscillator_enable <= (ps_r != PS_SLEEP);
      supply_enable     <= (ps_r == PS_RUN) & (power_circuit_select != 3'h0);
      outputs_to_vdd    <= (ps_r != PS_RUN);
      display_off_link  <= ~display_on | (ps_r != PS_RUN);
      // Indicator output follows the blink phase; frame polarity output held low
      static_indicator_output <= ind_on_r & (ps_r != PS_SLEEP) & blink_phase;
      frame_polarity_output   <= 1'b0;
    end
  end

endmodule

// File: verif/lcd_cmd_checker.sv
// Port-level assertions for the LCD command decoder.
// Assumes parallel commands and one clock; bound to every decoder instance.
`timescale 1ns/100ps
module lcd_cmd_checker (
  // Clock and reset
  input wire       sys_clk,
  input wire       rst,
  // Host port
  input wire       command_data_select,
  input wire       host_write,
  input wire       host_read,
  input wire [7:0] host_data,
  input wire       serial_select,
  // Observed state
  input wire [7:0] status_byte,
  input wire [7:0] column_address,
  input wire       common_scan_direction,
  input wire [2:0] power_circuit_select,
  input wire [4:0] contrast_level,
  input wire       contrast_enable,
  input wire       display_on,
  input wire       sleep_mode,
  input wire       standby_mode,
  input wire       oscillator_enable,
  input wire       supply_enable,
  input wire       outputs_to_vdd,
  input wire       test_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire cmd = host_write && !command_data_select && !serial_select && !status_byte[7];
  wire dwr = host_write && command_data_select && !serial_select;
  wire drd = host_read && command_data_select && !serial_select;
  reg  rmw_r;
  reg  ind_r;
  ////////////////////////////////////////////////////////////////
  // Mode shadows, kept here so no assertion leans on design internals
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rmw_r <= 1'b0;
      ind_r <= 1'b0;
    end else if (cmd) begin
      if (host_data == 8'he0) rmw_r <= 1'b1;
      if (host_data == 8'hee) rmw_r <= 1'b0;
      if (host_data[7:1] == 7'h56) ind_r <= host_data[0];
    end
  end
  sequence allon_s;
    cmd && host_data == 8'ha5 && !display_on;
  endsequence
  sequence sreset_s;
    cmd && host_data == 8'he2;
  endsequence
  ////////////////////////////////////////////////////////////////
  contrast_load_a: assert property (cmd && host_data[7:5] == 3'b100 |=> contrast_level == $past(host_data[4:0]))
    else $error("contrast level not loaded");
  contrast_off_a: assert property (1'b1 |=> contrast_enable == ($past(contrast_level) != 5'h00))
    else $error("contrast enable wrong");
  power_load_a: assert property (cmd && host_data[7:3] == 5'h05 |=> power_circuit_select == $past(host_data[2:0]))
    else $error("power select not loaded");
  scan_dir_a: assert property (cmd && host_data[7:4] == 4'hc |=> common_scan_direction == $past(host_data[3]))
    else $error("scan direction wrong");
  soft_reset_a: assert property (sreset_s |=> column_address == 8'h00 && !common_scan_direction && !test_mode
    && $stable(power_circuit_select)) else $error("soft reset effect wrong");
  test_flag_a: assert property (cmd && host_data[7:4] == 4'hf |=> test_mode == ($past(host_data) != 8'hf0))
    else $error("test flag wrong");
  rmw_read_a: assert property (rmw_r && drd |=> $stable(column_address))
    else $error("column moved on read");
  rmw_write_a: assert property (rmw_r && dwr && column_address < 8'h83 |=> column_address == $past(column_address) + 8'h01)
    else $error("column not advanced on write");
  sleep_entry_a: assert property (allon_s ##0 !ind_r |-> ##[1:3] sleep_mode)
    else $error("sleep not entered");
  standby_entry_a: assert property (allon_s ##0 ind_r |-> ##[1:3] standby_mode)
    else $error("standby not entered");
  sleep_out_a: assert property (sleep_mode |-> !oscillator_enable && !supply_enable && outputs_to_vdd)
    else $error("sleep outputs wrong");
  standby_out_a: assert property (standby_mode |-> oscillator_enable && !supply_enable && outputs_to_vdd)
    else $error("standby outputs wrong");
  standby_reset_a: assert property (standby_mode ##0 sreset_s |-> ##[1:4] sleep_mode)
    else $error("reset in standby did not sleep");
endmodule

bind lcd_driver_command_decoder lcd_cmd_checker chk_inst (.sys_clk, .rst, .command_data_select, .host_write,
  .host_read, .host_data, .serial_select, .status_byte, .column_address, .common_scan_direction,
  .power_circuit_select, .contrast_level, .contrast_enable, .display_on, .sleep_mode, .standby_mode,
  .oscillator_enable, .supply_enable, .outputs_to_vdd, .test_mode);

// File: verif/host_model.sv
// Host processor model: byte writes, data reads and serial command bytes.
// Assumes the decoder samples on sys_clk rising edges; tasks are called by the bench.
`timescale 1ns/100ps
module host_model (
  // Clock and status
  input  wire       sys_clk,
  input  wire [7:0] status_byte,
  // Parallel port
  output reg        command_data_select = 1'b0,
  output reg        host_write          = 1'b0,
  output reg        host_read           = 1'b0,
  output reg  [7:0] host_data           = 8'h00,
  // Serial port
  output reg        serial_select       = 1'b0,
  output reg        serial_cs           = 1'b0,
  output reg        serial_clk_rise     = 1'b0,
  output reg        serial_bit          = 1'b0
);
  task wr(input logic cds, input logic [7:0] b);
    begin
      @(posedge sys_clk);
      while (status_byte[7] === 1'b1) @(posedge sys_clk);
      command_data_select <= cds;
      host_data <= b;
      host_write <= 1'b1;
      @(posedge sys_clk);
      host_write <= 1'b0;
      // Released bus must not look like the last byte
      host_data <= ~b;
      @(posedge sys_clk);
    end
  endtask
  task rd;
    begin
      @(posedge sys_clk);
      command_data_select <= 1'b1;
      host_read <= 1'b1;
      @(posedge sys_clk);
      host_read <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task ser(input logic [7:0] b);
    integer i;
    begin
      @(posedge sys_clk);
      serial_select <= 1'b1;
      serial_cs <= 1'b1;
      for (i = 7; i >= 0; i = i - 1) begin
        @(posedge sys_clk);
        serial_bit <= b[i];
        serial_clk_rise <= 1'b1;
        @(posedge sys_clk);
        serial_clk_rise <= 1'b0;
        serial_bit <= ~b[i];
      end
      @(posedge sys_clk);
      serial_cs <= 1'b0;
      @(posedge sys_clk);
      serial_select <= 1'b0;
    end
  endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench: host model drives the decoder, scenarios judge its outputs.
// Assumes the checker binds itself from its own file.
`timescale 1ns/100ps
`define chk(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("mismatch %s expected %h seen %h", n, e, a); end end
module tb_top;
  reg        sys_clk = 1'b0;
  reg        rst = 1'b1;
  integer    fails = 0;
  integer    tests_run = 0;
  wire       command_data_select, host_write, host_read, serial_select, serial_cs, serial_clk_rise, serial_bit;
  wire [7:0] host_data, status_byte, column_address;
  wire [3:0] page_address;
  wire [5:0] start_line;
  wire [2:0] power_circuit_select;
  wire [4:0] contrast_level;
  wire       common_scan_direction, contrast_enable, sleep_mode, standby_mode, test_mode;
  host_model host_model_inst (.sys_clk, .status_byte, .command_data_select, .host_write, .host_read,
    .host_data, .serial_select, .serial_cs, .serial_clk_rise, .serial_bit);
  lcd_driver_command_decoder lcd_driver_command_decoder_inst (.sys_clk, .rst, .command_data_select,
    .host_write, .host_read, .host_data, .serial_select, .serial_cs, .serial_clk_rise, .serial_bit,
    .status_byte, .column_address, .page_address, .start_line, .ram_write_strobe(), .ram_read_strobe(),
    .ram_write_data(), .display_on(), .adc_reverse(), .reverse_display(), .entire_on(), .bias_select(),
    .common_scan_direction, .power_circuit_select, .contrast_level, .contrast_enable, .sleep_mode,
    .standby_mode, .oscillator_enable(), .supply_enable(), .outputs_to_vdd(), .display_off_link(),
    .static_indicator_output(), .frame_polarity_output(), .test_mode);
  ////////////////////////////////////////////////////////////////
  task t_contrast;
    begin
      host_model_inst.wr(1'b0, 8'h9f);
      @(posedge sys_clk);
      `chk("contrast", 5'h1f, contrast_level)
      `chk("contrast_enable", 1'b1, contrast_enable)
      host_model_inst.wr(1'b0, 8'h80);
      @(posedge sys_clk);
      `chk("contrast", 5'h00, contrast_level)
      `chk("contrast_enable", 1'b0, contrast_enable)
    end
  endtask
  task t_power;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        host_model_inst.wr(1'b0, {5'h05, i[2:0]});
        `chk("power", i[2:0], power_circuit_select)
      end
      host_model_inst.wr(1'b0, 8'hcf);
      `chk("scan", 1'b1, common_scan_direction)
      host_model_inst.wr(1'b0, 8'hc7);
      `chk("scan", 1'b0, common_scan_direction)
    end
  endtask
  task t_rmw;
    begin
      host_model_inst.wr(1'b0, 8'h11);
      host_model_inst.wr(1'b0, 8'h05);
      host_model_inst.wr(1'b0, 8'he0);
      host_model_inst.wr(1'b1, 8'haa);
      host_model_inst.rd;
      `chk("column", 8'h16, column_address)
      host_model_inst.wr(1'b1, 8'h55);
      `chk("column", 8'h17, column_address)
      host_model_inst.wr(1'b0, 8'h8a);
      `chk("contrast", 5'h0a, contrast_level)
      host_model_inst.wr(1'b0, 8'hee);
      `chk("column", 8'h15, column_address)
    end
  endtask
  task t_reset;
    begin
      host_model_inst.wr(1'b0, 8'hb3);
      host_model_inst.wr(1'b0, 8'h45);
      host_model_inst.wr(1'b0, 8'hc8);
      host_model_inst.wr(1'b0, 8'h2d);
      host_model_inst.wr(1'b0, 8'hf5);
      `chk("test", 1'b1, test_mode)
      host_model_inst.wr(1'b0, 8'hf0);
      `chk("test", 1'b0, test_mode)
      host_model_inst.wr(1'b0, 8'hf3);
      host_model_inst.wr(1'b0, 8'he2);
      repeat (4) @(posedge sys_clk);
      `chk("page", 4'h0, page_address)
      `chk("start", 6'h00, start_line)
      `chk("column", 8'h00, column_address)
      `chk("scan", 1'b0, common_scan_direction)
      `chk("power", 3'h5, power_circuit_select)
      `chk("test", 1'b0, test_mode)
    end
  endtask
  task t_serial;
    begin
      host_model_inst.ser(8'h9c);
      repeat (3) @(posedge sys_clk);
      `chk("serial contrast", 5'h1c, contrast_level)
    end
  endtask
  task t_pin_reset;
    begin
      host_model_inst.wr(1'b0, 8'h2f);
      host_model_inst.wr(1'b0, 8'hf7);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      `chk("power", 3'h0, power_circuit_select)
      `chk("test", 1'b0, test_mode)
    end
  endtask
  task t_save;
    begin
      host_model_inst.wr(1'b0, 8'had);
      host_model_inst.wr(1'b0, 8'hae);
      host_model_inst.wr(1'b0, 8'ha5);
      repeat (3) @(posedge sys_clk);
      `chk("standby", 1'b1, standby_mode)
      host_model_inst.wr(1'b0, 8'he2);
      repeat (4) @(posedge sys_clk);
      `chk("sleep", 1'b1, sleep_mode)
      host_model_inst.wr(1'b0, 8'ha4);
      repeat (3) @(posedge sys_clk);
      `chk("sleep", 1'b0, sleep_mode)
      host_model_inst.wr(1'b0, 8'hac);
      host_model_inst.wr(1'b0, 8'hae);
      host_model_inst.wr(1'b0, 8'ha5);
      repeat (3) @(posedge sys_clk);
      `chk("sleep", 1'b1, sleep_mode)
      `chk("standby", 1'b0, standby_mode)
      host_model_inst.wr(1'b0, 8'had);
      host_model_inst.wr(1'b0, 8'ha4);
      repeat (3) @(posedge sys_clk);
      `chk("sleep", 1'b0, sleep_mode)
      host_model_inst.wr(1'b0, 8'hae);
      host_model_inst.wr(1'b0, 8'ha5);
      host_model_inst.wr(1'b0, 8'ha4);
      repeat (3) @(posedge sys_clk);
      `chk("standby", 1'b0, standby_mode)
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task results;
    begin
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails = fails + 1;
    results;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_contrast;
    t_power;
    t_rmw;
    t_reset;
    t_serial;
    t_pin_reset;
    t_save;
    results;
  end
endmodule
